//--- logic/usbhp_pipe_regs.sv
// Host pipe configuration and status registers with AHB-Lite slave
`timescale 1ns/100ps
module usbhp_pipe_regs (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic usb_reset_req,
	input wire usbhp_pkg::usbhp_evt_t [usbhp_pkg::NPIPE-1:0] evt,
	output usbhp_pkg::usbhp_ctl_t [usbhp_pkg::NPIPE-1:0] ctl
);
	import usbhp_pkg::*;

	usbhp_state_t s_r;
	usbhp_state_t s_nxt;

	// Word index of an address within a seven-word bank
	function automatic logic hit(input logic [11:0] a,
			input logic [11:0] base);
		logic [11:0] off;
		off = a - base;
		hit = (off[11:5] == 7'h00) && (off[1:0] == 2'h0) &&
			(off[4:2] != 3'h7);
	endfunction

	function automatic logic [2:0] widx(input logic [11:0] a,
			input logic [11:0] base);
		logic [11:0] off;
		off = a - base;
		widx = off[4:2];
	endfunction

	// Bytes in one bank for a size code
	function automatic logic [10:0] bank_bytes(input logic [2:0] code);
		bank_bytes = BANK_MIN_BYTES << code;
	endfunction

	// Whole buffer taken by one pipe
	function automatic logic [15:0] pipe_bytes(input usbhp_cfg_t c);
		logic [15:0] b;
		b = {5'h00, bank_bytes(c.bank_size_sel)};
		pipe_bytes = b * {14'h0000, c.bank_count_sel} + b;
	endfunction

	// Status word of one pipe
	function automatic logic [31:0] status_word(input usbhp_pipe_t p);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[7:0] = p.flags;
		w[ST_TOGGLE +: 2] = p.toggle_state;
		w[ST_BUSY +: 2] = p.busy_bank_count;
		w[ST_BANK +: 2] = p.active_bank;
		w[ST_ACCESS] = p.access_allowed;
		w[ST_CONFIG_VALID] = p.config_valid;
		w[ST_COUNT +: 11] = p.fifo_byte_count;
		status_word = w;
	endfunction

	// Decoded bus strobes and write fields
	logic acc;
	logic wr_cfg;
	logic wr_clr;
	logic wr_ien;
	logic [2:0] idx_cfg;
	logic [2:0] idx_clr;
	logic [2:0] idx_ien;
	logic [15:0] used_total;
	usbhp_cfg_t wcfg;

	// Bus decode and buffer bookkeeping
	always_comb begin
		acc = hsel && htrans[1] && hready;
		wr_cfg = s_r.a_valid && s_r.a_write && hit(s_r.a_addr, CFG_BASE);
		wr_clr = s_r.a_valid && s_r.a_write && hit(s_r.a_addr, CLR_BASE);
		wr_ien = s_r.a_valid && s_r.a_write && hit(s_r.a_addr, IEN_BASE);
		idx_cfg = widx(s_r.a_addr, CFG_BASE);
		idx_clr = widx(s_r.a_addr, CLR_BASE);
		idx_ien = widx(s_r.a_addr, IEN_BASE);
		// Configuration fields from the write data
		wcfg.poll_period_ms = hwdata[31:24];
		wcfg.target_endpoint_num = hwdata[19:16];
		wcfg.transfer_type_sel = hwdata[13:12];
		wcfg.auto_bank_switch = hwdata[10];
		wcfg.token_sel = hwdata[9:8];
		wcfg.bank_size_sel = hwdata[6:4];
		wcfg.bank_count_sel = hwdata[3:2];
		wcfg.mem_allocate = hwdata[1];
		// Buffer bytes held by valid allocated pipes
		used_total = 16'h0000;
		for (int j = 0; j < NPIPE; j++) begin
			if (s_r.pipe[j].cfg.mem_allocate && s_r.pipe[j].config_valid) begin
				used_total = used_total + pipe_bytes(s_r.pipe[j].cfg);
			end
		end
	end

	// Per-pipe working values of the next-state process
	logic [15:0] used_other;
	logic [15:0] need;
	logic [10:0] bsize;
	logic is_in;
	logic is_iso;
	logic is_ctrl;
	logic late_bank;
	logic busy_irq;
	logic [7:0] set;
	logic [7:0] clr;
	logic [1:0] last_bank;
	usbhp_pipe_t p;

	// Next state of every pipe and of the bus slave
	always_comb begin
		s_nxt = s_r;
		used_other = 16'h0000;
		need = 16'h0000;
		bsize = 11'h000;
		is_in = 1'b0;
		is_iso = 1'b0;
		is_ctrl = 1'b0;
		late_bank = 1'b0;
		busy_irq = 1'b0;
		set = 8'h00;
		clr = 8'h00;
		last_bank = 2'h0;
		p = s_r.pipe[0];

		// Address phase taken; one wait state, then data phase ends
		s_nxt.hresp = 1'b0;
		if (s_r.a_valid) begin
			s_nxt.a_valid = 1'b0;
			s_nxt.hreadyout = 1'b1;
		end else if (acc) begin
			s_nxt.a_valid = 1'b1;
			s_nxt.a_write = hwrite;
			s_nxt.a_addr = haddr[11:0];
			s_nxt.hreadyout = 1'b0;
			s_nxt.hrdata = 32'h0000_0000;
			// Read data captured in the address phase
			if (!hwrite && hit(haddr[11:0], CFG_BASE)) begin
				p = s_r.pipe[widx(haddr[11:0], CFG_BASE)];
				s_nxt.hrdata = {p.cfg.poll_period_ms, 4'h0,
					p.cfg.target_endpoint_num, 2'h0,
					p.cfg.transfer_type_sel, 1'b0,
					p.cfg.auto_bank_switch, p.cfg.token_sel, 1'b0,
					p.cfg.bank_size_sel, p.cfg.bank_count_sel,
					p.cfg.mem_allocate, 1'b0};
			end else if (!hwrite && hit(haddr[11:0], STA_BASE)) begin
				s_nxt.hrdata = status_word(
					s_r.pipe[widx(haddr[11:0], STA_BASE)]);
			end else if (!hwrite && hit(haddr[11:0], IEN_BASE)) begin
				p = s_r.pipe[widx(haddr[11:0], IEN_BASE)];
				s_nxt.hrdata = {19'h00000, p.busy_bank_irq_en, 4'h0,
					p.irq_en};
			end
			// Clear words and unmapped words read as zero
		end

		for (int i = 0; i < NPIPE; i++) begin
			// Direction, type and bank geometry of this pipe
			p = s_r.pipe[i];
			is_in = p.cfg.token_sel == TOK_IN;
			is_iso = p.cfg.transfer_type_sel == TYP_ISO;
			is_ctrl = p.cfg.transfer_type_sel == TYP_CTRL;
			bsize = bank_bytes(p.cfg.bank_size_sel);
			last_bank = p.cfg.bank_count_sel;
			p.zlp_req = 1'b0;

			// Configuration write; allocate re-checks the fit
			if (wr_cfg && idx_cfg == 3'(i)) begin
				p.cfg = wcfg;
				if (wcfg.mem_allocate) begin
					used_other = used_total;
					if (s_r.pipe[i].cfg.mem_allocate &&
							s_r.pipe[i].config_valid) begin
						used_other = used_total - pipe_bytes(s_r.pipe[i].cfg);
					end
					need = used_other + pipe_bytes(wcfg);
					p.config_valid = (wcfg.bank_count_sel != BANKS_RSVD) &&
						(wcfg.bank_count_sel <=
							(i == 0 ? PIPE0_MAX_BANKS : PIPE_MAX_BANKS)) &&
						(wcfg.bank_size_sel <=
							(i == 0 ? PIPE0_MAX_SIZE : PIPE_MAX_SIZE)) &&
						(need <= DPRAM_BYTES) &&
						(need >= used_other);
				end
			end
			// Interrupt enable word write
			if (wr_ien && idx_ien == 3'(i)) begin
				p.irq_en = hwdata[7:0];
				p.busy_bank_irq_en = hwdata[IEN_BUSY];
			end

			// Write-one-to-clear; a same-cycle hardware set still wins
			clr = 8'h00;
			if (wr_clr && idx_clr == 3'(i)) begin
				clr = hwdata[7:0] & CLR_MASK;
			end

			// Hardware events
			set = 8'h00;
			set[F_RX] = evt[i].rx_stored;
			if (evt[i].bank_free) begin
				if (is_ctrl && p.cfg.token_sel == TOK_SETUP) begin
					set[F_SETUP_UNDER] = 1'b1;
				end else begin
					set[F_OUT] = 1'b1;
				end
			end
			// Iso or interrupt OUT slot with no busy bank sends a zero-length packet
			late_bank = evt[i].out_slot && p.busy_bank_count == 2'h0 &&
				(is_iso || p.cfg.transfer_type_sel == TYP_INTR);
			if (late_bank) begin
				set[F_SETUP_UNDER] = 1'b1;
				p.zlp_req = 1'b1;
			end
			// Handshake, length and error events
			set[F_NAK] = evt[i].nak;
			set[F_OVER] = evt[i].overflow;
			set[F_STALL_CRC] = is_iso ? evt[i].crc_err : evt[i].stall;
			set[F_SHORT] = evt[i].rx_stored &&
				(evt[i].rx_len < bsize);
			// Sticky flags; a hardware set beats a clear
			p.flags = (p.flags & ~clr) | set;
			p.flags[F_FAULT] = evt[i].err_evt ||
				(s_r.pipe[i].flags[F_FAULT] && evt[i].err_src);

			// Stall freezes the pipe until its flag is cleared
			if (!is_iso && evt[i].stall) begin
				p.frozen = 1'b1;
			end else if (clr[F_STALL_CRC]) begin
				p.frozen = 1'b0;
			end

			// Next OUT toggle or toggle of the stored IN packet
			if (evt[i].pkt_done) begin
				p.toggle_state = {1'b0, is_in ? evt[i].pkt_pid :
					!evt[i].pkt_pid};
			end

			// Busy banks, limited to the configured bank count and to at most two
			if (evt[i].bank_take && !evt[i].bank_give) begin
				if (p.busy_bank_count < 2'h2 &&
						p.busy_bank_count < last_bank + 2'h1) begin
					p.busy_bank_count = p.busy_bank_count + 2'h1;
				end
			end else if (evt[i].bank_give && !evt[i].bank_take) begin
				if (p.busy_bank_count != 2'h0) begin
					p.busy_bank_count = p.busy_bank_count - 2'h1;
				end
			end

			// Bank switch and count reset one clock after the access bit
			if (p.switch_pend) begin
				p.switch_pend = 1'b0;
				p.fifo_byte_count = 11'h000;
				if (!is_ctrl) begin
					p.active_bank = (p.active_bank >= last_bank) ? 2'h0 :
						p.active_bank + 2'h1;
				end
			end else begin
				if (evt[i].bank_done && p.cfg.auto_bank_switch) begin
					p.switch_pend = 1'b1;
				end
				// IN fills from the link, OUT fills from software
				if (is_in) begin
					if (evt[i].link_byte && !evt[i].sw_byte) begin
						p.fifo_byte_count = p.fifo_byte_count + 11'h001;
					end else if (evt[i].sw_byte && !evt[i].link_byte &&
							p.fifo_byte_count != 11'h000) begin
						p.fifo_byte_count = p.fifo_byte_count - 11'h001;
					end
				end else begin
					if (evt[i].sw_byte && !evt[i].link_byte) begin
						p.fifo_byte_count = p.fifo_byte_count + 11'h001;
					end else if (evt[i].link_byte && !evt[i].sw_byte &&
							p.fifo_byte_count != 11'h000) begin
						p.fifo_byte_count = p.fifo_byte_count - 11'h001;
					end
				end
			end

			// Access allowed while room or data remains
			p.access_allowed = (is_in ? (p.fifo_byte_count != 11'h000) :
				(p.fifo_byte_count < bsize)) &&
				!(p.flags[F_STALL_CRC] && !is_iso) &&
				!p.flags[F_FAULT] && !p.switch_pend;

			// Bus reset clears the configuration fields except the token code
			if (usb_reset_req) begin
				p.cfg.bank_count_sel = 2'h0;
				p.cfg.bank_size_sel = 3'h0;
				p.cfg.auto_bank_switch = 1'b0;
				p.cfg.transfer_type_sel = 2'h0;
				p.cfg.target_endpoint_num = 4'h0;
				p.cfg.poll_period_ms = 8'h00;
				p.cfg.mem_allocate = 1'b0;
			end

			// Interrupt request from enabled flags and bank fill state
			busy_irq = p.busy_bank_irq_en && (is_in ?
				(p.busy_bank_count == 2'h0) :
				(p.busy_bank_count >= last_bank + 2'h1 ||
				p.busy_bank_count == 2'h2));
			// Level request from enabled flags or bank state
			p.pipe_irq = (|(p.flags & p.irq_en)) || busy_irq;
			// Commit this pipe's next state
			s_nxt.pipe[i] = p;
		end
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			// Idle bus with ready high, all pipes cleared
			s_r <= '0;
			s_r.hreadyout <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register
	assign hrdata = s_r.hrdata;
	assign hreadyout = s_r.hreadyout;
	assign hresp = s_r.hresp;
	// Per-pipe controls to the transaction engine
	generate
		for (genvar g = 0; g < NPIPE; g++) begin : g_ctl
			assign ctl[g].cfg = s_r.pipe[g].cfg;
			assign ctl[g].active_bank = s_r.pipe[g].active_bank;
			assign ctl[g].access_allowed = s_r.pipe[g].access_allowed;
			assign ctl[g].frozen = s_r.pipe[g].frozen;
			assign ctl[g].zlp_req = s_r.pipe[g].zlp_req;
			assign ctl[g].pipe_irq = s_r.pipe[g].pipe_irq;
		end
	endgenerate

endmodule // usbhp_pipe_regs

//--- logic/usbhp_pkg.sv
// Constants and types for the host pipe configuration and status block
// What this block does
// - bank-count code picks one, two, three banks
// - bank-size code picks 8 to 1024 bytes
// - USB bus reset clears pipe configuration fields except token code
// - token code selects SETUP, IN or OUT
// - auto switch advances bank when bank ready, except on control pipes
// - type code: control, isochronous, bulk, interrupt
// - stored message sets received-data flag, may interrupt
// - free outgoing bank sets OUT or SETUP flag
// - late iso/interrupt OUT sends ZLP, sets underflow
// - fault flag follows error, clears with source
// - received NAK sets NAK flag, may interrupt
// - too much received data sets overflow flag
// - STALL on non-iso pipe sets bit 6, freezes
// - isochronous pipes use bit 6 for CRC
// - packet shorter than bank sets short flag
// - toggle shows DATA0/DATA1 per direction
// - busy-bank count reported; full/empty may interrupt
// - bank and count lag access bit one clock
// - access bit: room/data, low on stall/fault
// - allocate updates configuration-valid from size checks
// - byte count follows writes, reads, link bytes
// - clear register: ones clear flags except fault, reads zero
package usbhp_pkg;

	localparam int NPIPE = 7;

	// Register word bases, one aligned word per pipe
	localparam logic [11:0] CFG_BASE = 12'h500;
	localparam logic [11:0] STA_BASE = 12'h530;
	localparam logic [11:0] CLR_BASE = 12'h560;
	localparam logic [11:0] IEN_BASE = 12'h5e0;

	// Status word and interrupt enable word field positions
	localparam int F_RX = 0;
	localparam int F_OUT = 1;
	localparam int F_SETUP_UNDER = 2;
	localparam int F_FAULT = 3;
	localparam int F_NAK = 4;
	localparam int F_OVER = 5;
	localparam int F_STALL_CRC = 6;
	localparam int F_SHORT = 7;
	localparam int ST_TOGGLE = 8;
	localparam int ST_BUSY = 12;
	localparam int ST_BANK = 14;
	localparam int ST_ACCESS = 16;
	localparam int ST_CONFIG_VALID = 18;
	localparam int ST_COUNT = 20;
	localparam int IEN_BUSY = 12;

	// Flags that the clear register may touch; fault clears with source
	localparam logic [7:0] CLR_MASK = 8'hf7;

	localparam logic [1:0] TOK_SETUP = 2'h0;
	localparam logic [1:0] TOK_IN = 2'h1;
	localparam logic [1:0] TOK_OUT = 2'h2;
	localparam logic [1:0] TYP_CTRL = 2'h0;
	localparam logic [1:0] TYP_ISO = 2'h1;
	localparam logic [1:0] TYP_BULK = 2'h2;
	localparam logic [1:0] TYP_INTR = 2'h3;
	localparam logic [1:0] BANKS_RSVD = 2'h3;

	// Smallest bank is 8 bytes; size code doubles it
	localparam logic [10:0] BANK_MIN_BYTES = 11'h008;
	// Per-pipe limits and shared buffer size
	localparam logic [1:0] PIPE0_MAX_BANKS = 2'h0;
	localparam logic [2:0] PIPE0_MAX_SIZE = 3'h3;
	localparam logic [1:0] PIPE_MAX_BANKS = 2'h2;
	localparam logic [2:0] PIPE_MAX_SIZE = 3'h7;
	localparam logic [15:0] DPRAM_BYTES = 16'h1000;

	typedef struct packed {
		logic [7:0] poll_period_ms;
		logic [3:0] target_endpoint_num;
		logic [1:0] transfer_type_sel;
		logic auto_bank_switch;
		logic [1:0] token_sel;
		logic [2:0] bank_size_sel;
		logic [1:0] bank_count_sel;
		logic mem_allocate;
	} usbhp_cfg_t;

	// Per-pipe events from the USB transaction engine, one-cycle pulses except rx_len and the err_src level
	typedef struct packed {
		logic rx_stored;
		logic [10:0] rx_len;
		logic bank_free;
		logic out_slot;
		logic err_evt;
		logic err_src;
		logic nak;
		logic overflow;
		logic stall;
		logic crc_err;
		logic pkt_done;
		logic pkt_pid;
		logic link_byte;
		logic sw_byte;
		logic bank_take;
		logic bank_give;
		logic bank_done;
	} usbhp_evt_t;

	// Per-pipe controls back to the engine
	typedef struct packed {
		usbhp_cfg_t cfg;
		logic [1:0] active_bank;
		logic access_allowed;
		logic frozen;
		logic zlp_req;
		logic pipe_irq;
	} usbhp_ctl_t;

	typedef struct packed {
		usbhp_cfg_t cfg;
		logic [7:0] flags;
		logic [7:0] irq_en;
		logic busy_bank_irq_en;
		logic [1:0] toggle_state;
		logic [1:0] busy_bank_count;
		logic [1:0] active_bank;
		logic access_allowed;
		logic config_valid;
		logic [10:0] fifo_byte_count;
		logic switch_pend;
		logic frozen;
		logic zlp_req;
		logic pipe_irq;
	} usbhp_pipe_t;

	typedef struct packed {
		usbhp_pipe_t [NPIPE-1:0] pipe;
		logic a_valid;
		logic a_write;
		logic [11:0] a_addr;
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
	} usbhp_state_t;

endpackage

//--- sim/usbhp_pipe_regs_asserts.sv
// Concurrent checks on the host pipe register block ports
`timescale 1ns/100ps
module usbhp_pipe_regs_asserts (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic usb_reset_req,
	input wire usbhp_pkg::usbhp_evt_t [usbhp_pkg::NPIPE-1:0] evt,
	input wire usbhp_pkg::usbhp_ctl_t [usbhp_pkg::NPIPE-1:0] ctl
);
	import usbhp_pkg::*;
	localparam int P = 1;
	usbhp_cfg_t c;
	usbhp_evt_t e;
	logic frz;
	logic acc;
	logic [1:0] bk;
	// Watch one pipe
	assign c = ctl[P].cfg;
	assign e = evt[P];
	assign frz = ctl[P].frozen;
	assign acc = ctl[P].access_allowed;
	assign bk = ctl[P].active_bank;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	sequence s_take;
		hsel && htrans[1] && hready && hreadyout;
	endsequence
	sequence s_hard_stall;
		e.stall && c.transfer_type_sel != TYP_ISO;
	endsequence
	sequence s_auto_done;
		e.bank_done && c.auto_bank_switch &&
			c.transfer_type_sel != TYP_CTRL && c.bank_count_sel == 2'h1;
	endsequence
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	a_one_wait: assert property (s_take |=> !hreadyout ##1 hreadyout)
		else $error("wait state count wrong");
	a_reset_cfg: assert property (usb_reset_req |=>
		c.bank_count_sel == 2'h0 && c.bank_size_sel == 3'h0 &&
		!c.auto_bank_switch && c.transfer_type_sel == 2'h0 &&
		c.target_endpoint_num == 4'h0 && c.poll_period_ms == 8'h0)
		else $error("bus reset left config");
	a_stall_frz: assert property (s_hard_stall |=> frz)
		else $error("stall did not freeze");
	a_stall_acc: assert property (s_hard_stall |=> ##[0:1] !acc)
		else $error("access high after stall");
	a_iso_nofrz: assert property (
		e.stall && c.transfer_type_sel == TYP_ISO && !frz |=> !frz)
		else $error("iso pipe frozen");
	a_zlp_cause: assert property (
		ctl[P].zlp_req |-> $past(e.out_slot) && c.transfer_type_sel[0])
		else $error("zero length packet without cause");
	a_auto_adv: assert property (s_auto_done |=> !acc ##1 $changed(bk))
		else $error("bank did not advance");
	a_no_switch: assert property (
		e.bank_done && !c.auto_bank_switch |=> $stable(bk) [*2])
		else $error("bank moved without auto switch");
endmodule // usbhp_pipe_regs_asserts

bind usbhp_pipe_regs usbhp_pipe_regs_asserts u_chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.usb_reset_req(usb_reset_req), .evt(evt), .ctl(ctl));

//--- sim/usbhp_dev_model.sv
// Behavioural USB device side: event pulses on one pipe
`timescale 1ns/100ps
module usbhp_dev_model #(parameter int PIPE = 1) (
	input wire logic hclk,
	input wire logic go,
	input wire logic [4:0] bsel,
	input wire logic [10:0] len,
	input wire logic src,
	output usbhp_pkg::usbhp_evt_t [usbhp_pkg::NPIPE-1:0] evt
);
	import usbhp_pkg::*;
	usbhp_evt_t [NPIPE-1:0] pulse_nxt;
	// One-cycle pulse per request; error source is a level
	always @(posedge hclk) begin
		pulse_nxt = '0;
		pulse_nxt[PIPE].err_src = src;
		pulse_nxt[PIPE].rx_len = len;
		if (go)
			pulse_nxt[PIPE][bsel] = 1'b1;
		evt <= pulse_nxt;
	end
endmodule // usbhp_dev_model

//--- sim/tb_usbhp_pipe_regs.sv
// Testbench for the host pipe configuration and status block
`timescale 1ns/100ps
module tb_usbhp_pipe_regs;
	import usbhp_pkg::*;
	logic hclk, hresetn, hsel, hwrite, usb_reset_req, hreadyout, hresp;
	logic go, src;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [4:0] bsel;
	logic [10:0] len;
	logic [31:0] haddr, hwdata, hrdata, v, w;
	usbhp_evt_t [NPIPE-1:0] evt;
	usbhp_ctl_t [NPIPE-1:0] ctl;
	int fail_count = 0;
	int samples_checked = 0;
	int i;
	int eb[4] = '{14, 10, 9, 8};
	int fb[4] = '{1, 4, 5, 6};
	localparam logic [11:0] P = 12'h004;

	usbhp_pipe_regs DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp),
		.usb_reset_req(usb_reset_req), .evt(evt), .ctl(ctl));
	usbhp_dev_model u_dev (.hclk(hclk), .go(go), .bsel(bsel), .len(len),
		.src(src), .evt(evt));

	// Clock
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	// Single AHB transfer; read data lands in v
	task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		haddr <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		v = hrdata;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Masked read compare
	task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(v & m, e);
	endtask

	// One device event; returns just after the design has taken it
	task ev(input logic [4:0] b, input logic [10:0] l);
		@(posedge hclk);
		go <= 1'b1;
		bsel <= b;
		len <= l;
		@(posedge hclk);
		go <= 1'b0;
		@(posedge hclk);
		#1;
	endtask

	task print_verdict;
		if (fail_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Watchdog
	initial begin
		#100000;
		fail_count++;
		print_verdict;
	end

	// Main sequence
	initial begin
		{hresetn, hwrite, usb_reset_req, go, src} = '0;
		hsel = 1'b1;
		hsize = 3'h2;
		{htrans, bsel, len, haddr, hwdata} = '0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		rd(STA_BASE + P, 32'hfffeffff, 32'h0);
		rd(CLR_BASE + P, 32'hffffffff, 32'h0);
		rd(12'h7fc, 32'hffffffff, 32'h0);
		for (i = 0; i < 4; i++) begin
			w = {8'(i * 5), 4'h0, 4'(15 - i), 2'h0, 2'(i), 1'b0, 1'(i),
				2'(i % 3), 1'b0, 3'(2 * i + 1), 2'(i % 3), 2'h0};
			bus(1'b1, CFG_BASE + P, w);
			rd(CFG_BASE + P, 32'hffffffff, w);
			chk({30'h0, ctl[1].cfg.transfer_type_sel}, 32'(i));
		end
		bus(1'b1, CFG_BASE + P, 32'h0b0f3676);
		@(posedge hclk);
		usb_reset_req <= 1'b1;
		@(posedge hclk);
		usb_reset_req <= 1'b0;
		rd(CFG_BASE + P, 32'hffffffff, 32'h200);
		bus(1'b1, CFG_BASE + P, 32'h2234);
		w = 32'h0;
		for (i = 0; i < 4; i++) begin
			ev(5'(eb[i]), 11'h0);
			w |= 32'h1 << fb[i];
			rd(STA_BASE + P, 32'hff, w);
		end
		chk({31'h0, ctl[1].frozen}, 32'h1);
		rd(STA_BASE + P, 32'h10000, 32'h0);
		bus(1'b1, CLR_BASE + P, 32'h72);
		rd(STA_BASE + P, 32'hff, 32'h0);
		@(posedge hclk);
		src <= 1'b1;
		ev(5'd12, 11'h0);
		bus(1'b1, CLR_BASE + P, 32'h8);
		rd(STA_BASE + P, 32'h10008, 32'h8);
		@(posedge hclk);
		src <= 1'b0;
		repeat (2) @(posedge hclk);
		rd(STA_BASE + P, 32'h8, 32'h0);
		bus(1'b1, CFG_BASE + P, 32'h1230);
		ev(5'd7, 11'h0);
		ev(5'd8, 11'h0);
		rd(STA_BASE + P, 32'h40, 32'h40);
		chk({31'h0, ctl[1].frozen}, 32'h0);
		ev(5'd13, 11'h0);
		chk({31'h0, ctl[1].zlp_req}, 32'h1);
		rd(STA_BASE + P, 32'h4, 32'h4);
		bus(1'b1, CFG_BASE + P, 32'h2130);
		bus(1'b1, CLR_BASE + P, 32'hff);
		ev(5'd26, 11'h5);
		rd(STA_BASE + P, 32'h81, 32'h81);
		bus(1'b1, CLR_BASE + P, 32'hff);
		ev(5'd26, 11'h40);
		rd(STA_BASE + P, 32'h81, 32'h1);
		bus(1'b1, CFG_BASE + P, 32'h2234);
		repeat (3) ev(5'd3, 11'h0);
		rd(STA_BASE + P, 32'h7ff00000, 32'h00300000);
		bus(1'b1, CFG_BASE + P, 32'h223e);
		rd(STA_BASE + P, 32'h40000, 32'h0);
		bus(1'b1, CFG_BASE + P, 32'h2274);
		bus(1'b1, CFG_BASE + P, 32'h2276);
		rd(STA_BASE + P, 32'h40000, 32'h40000);
		bus(1'b1, CFG_BASE + P, 32'h2234);
		ev(5'd0, 11'h0);
		chk({30'h0, ctl[1].active_bank}, 32'h0);
		bus(1'b1, CFG_BASE + P, 32'h2634);
		ev(5'd0, 11'h0);
		@(posedge hclk);
		#1;
		chk({30'h0, ctl[1].active_bank}, 32'h1);
		rd(STA_BASE + P, 32'h7ff00000, 32'h0);
		ev(5'd6, 11'h0);
		rd(STA_BASE + P, 32'h300, 32'h100);
		bus(1'b1, IEN_BASE + P, 32'h1000);
		rd(IEN_BASE + P, 32'hffffffff, 32'h1000);
		ev(5'd2, 11'h0);
		chk({31'h0, ctl[1].pipe_irq}, 32'h0);
		ev(5'd2, 11'h0);
		rd(STA_BASE + P, 32'h3000, 32'h2000);
		chk({31'h0, ctl[1].pipe_irq}, 32'h1);
		ev(5'd1, 11'h0);
		chk({31'h0, ctl[1].pipe_irq}, 32'h0);
		bus(1'b1, IEN_BASE + P, 32'h1);
		chk({31'h0, ctl[1].pipe_irq}, 32'h1);
		bus(1'b1, CLR_BASE + P, 32'h1);
		chk({31'h0, ctl[1].pipe_irq}, 32'h0);
		bus(1'b1, CFG_BASE + P, 32'h2134);
		ev(5'd6, 11'h0);
		ev(5'd4, 11'h0);
		rd(STA_BASE + P, 32'h7ff10300, 32'h00110000);
		print_verdict;
	end
endmodule // tb_usbhp_pipe_regs
